/* inc/asr_pkg.sv */
/*
  Shared constants and types of the asynchronous serial receiver:
  register map, field positions, reset values, sampler counts and state records.
  Assumes a 32-bit AHB-Lite register bus and one system clock.
*/
`default_nettype none

package asr_pkg;

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] OFS_TX_CTRL = 8'h00;
  localparam logic [7:0] OFS_RX_CTRL = 8'h04;
  localparam logic [7:0] OFS_RX_DATA = 8'h08;
  localparam logic [7:0] OFS_BAUD_CTRL = 8'h0c;
  localparam logic [7:0] OFS_DIV_LO = 8'h10;
  localparam logic [7:0] OFS_DIV_HI = 8'h14;
  localparam logic [7:0] OFS_PIN_DIR = 8'h18;
  localparam logic [7:0] OFS_IRQ_CTRL = 8'h1c;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // ==========================================================
  // Field positions
  localparam int SYNC_BIT = 4;
  localparam int HIGH_SPEED_BAUD_BIT = 2;
  localparam int TX_SHIFT_EMPTY_BIT = 1;
  localparam int SERIAL_PORT_ENABLE_BIT = 7;
  localparam int RX9_BIT = 6;
  localparam int CONTINUOUS_RECEIVE_ENABLE_BIT = 4;
  localparam int ADDRESS_DETECT_ENABLE_BIT = 3;
  localparam int FRAMING_ERROR_BIT = 2;
  localparam int OVERRUN_ERROR_BIT = 1;
  localparam int NINTH_RX_BIT_BIT = 0;
  localparam int RCIDL_BIT = 6;
  localparam int RECEIVE_POLARITY_INVERT_BIT = 5;
  localparam int WIDE_BAUD_COUNTER_BIT = 3;
  localparam int RX_DIR_BIT = 0;
  localparam int IRQ_EN_BIT = 0;
  localparam int IRQ_FLAG_BIT = 1;

  // ==========================================================
  // Writable masks and reset values
  localparam logic [7:0] TX_WR_MASK = 8'hfd;
  localparam logic [7:0] RC_WR_MASK = 8'hf8;
  localparam logic [7:0] BAUD_WR_MASK = 8'h38;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [1:0] PIN_DIR_RESET = 2'h0;

  // ==========================================================
  // Sampler counts: 16 ticks per bit, votes at 7, 8 and 9
  localparam int OVERSAMPLE = 16;
  localparam logic [3:0] VOTE_A = 4'h7;
  localparam logic [3:0] VOTE_B = 4'h8;
  localparam logic [3:0] VOTE_C = 4'h9;
  localparam logic [3:0] LAST_BIT_8 = 4'h7;
  localparam logic [3:0] LAST_BIT_9 = 4'h8;
  localparam logic [1:0] SLOW_PRESCALE = 2'h3;
  localparam logic [1:0] FIFO_DEPTH = 2'h2;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} asr_rx_e_t;

  typedef struct packed {
    logic framing_error;
    logic d9;
    logic [7:0] data;
  } asr_entry_t;

  typedef struct packed {
    logic [1:0] pre;
    logic [15:0] cnt;
    logic tick;
  } asr_brg_t;

  typedef struct packed {
    logic [7:0] tx_ctrl;
    logic [7:0] rc_ctrl;
    logic [7:0] baud_ctrl;
    logic [7:0] div_lo;
    logic [7:0] div_hi;
    logic [1:0] pin_dir;
    logic irq_en;
    logic brg_restart;
    logic [2:0] sync;
    logic line;
    logic line_prev;
    asr_rx_e_t rx_st;
    logic [3:0] phase;
    logic [1:0] smp;
    logic [3:0] bit_idx;
    logic [8:0] shift;
    asr_entry_t [1:0] mem;
    logic fifo_rd;
    logic [1:0] fifo_cnt;
    logic overrun_error;
    logic flag;
    logic irq;
    logic dp_act;
    logic dp_write;
    logic dp_hit;
    logic [7:0] dp_addr;
    logic hready;
    logic [31:0] hrdata;
  } asr_state_t;

  function automatic logic asr_maj3(input logic a, input logic b, input logic c);
    return (a & b) | (a & c) | (b & c);
  endfunction

endpackage

`default_nettype wire

/* rtl/asr_baud_gen.sv */
/*
  Baud generator: emits one tick per sixteenth of a bit.
  Assumes the divisor and mode bits come from registers on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module asr_baud_gen
  import asr_pkg::*;
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // Control
  input wire logic enable_in,
  input wire logic restart_in,
  input wire logic [15:0] divisor_in,
  input wire logic wide_in,
  input wire logic high_in,
  // Sample tick
  output logic tick_out
);

  asr_brg_t s;
  asr_brg_t n;
  logic [15:0] div;

  // ==========================================================
  // Divider: 4(n+1) clocks per tick in slow mode, n+1 otherwise
  always_comb
  begin
    n = s;
    n.tick = 1'b0;
    div = wide_in ? divisor_in : {8'h00, divisor_in[7:0]};
    if (!enable_in || restart_in)
    begin
      n.pre = 2'h0;
      n.cnt = div;
    end
    else if (s.pre != 2'h0)
    begin
      n.pre = s.pre - 2'h1;
    end
    else
    begin
      n.pre = (!wide_in && !high_in) ? SLOW_PRESCALE : 2'h0;
      if (s.cnt == 16'h0000)
      begin
        n.cnt = div;
        n.tick = 1'b1;
      end
      else
      begin
        n.cnt = s.cnt - 16'h0001;
      end
    end
  end

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      s <= '0;
    end
    else
    begin
      s <= n;
    end
  end

  assign tick_out = s.tick;

endmodule

`default_nettype wire

/* rtl/asr_top.sv */
/*
  Asynchronous serial receiver with AHB-Lite register slave, two-entry
  receive buffer, address detection and polarity inversion.
  Assumes one clock, an AHB-Lite master with word transfers, and a remote
  transmitter on the receive pin.
*/
// The address map and register access over AHB-Lite were chosen for this implementation.
// Overview of operation
// - Port enable activates; sync bit must be zero
// - Port runs only with enable and receive direction
// - Nine data bits when nine-bit mode set
// - Polarity invert treats line idle-low, data inverted
// - Continuous receive enable starts and stops reception
// - Flag rises on buffer load; interrupt if enabled
// - Data read returns low byte of oldest character
// - Clearing continuous receive clears overrun
// - Address detect in nine-bit mode keeps only ninth-bit-one characters
// - Delivered ninth bit reads one in address mode
// - Sixteen-times sampler; shift once per bit
// - Start rechecked at half bit; abort silently
// - Zero stop sample marks framing error
// - Two-entry buffer; third character sets overrun, blocks
`timescale 1ns/1ps
`default_nettype none

module asr_top
  import asr_pkg::*;
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // AHB-Lite slave
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic hreadyout_out,
  output logic [31:0] hrdata_out,
  output logic hresp_out,
  // Serial line
  input wire logic receive_pin_in,
  // Receive status
  output logic receive_flag_out,
  output logic receive_irq_out
);

  asr_state_t s;
  asr_state_t n;
  logic brg_tick;
  logic port_on;
  logic rx_on;
  logic level;
  logic fall;
  logic vote;
  logic d9;
  logic has;
  logic push_evt;
  logic pop_evt;
  asr_entry_t push_word;
  asr_entry_t top;
  logic [7:0] rd8;

  // ==========================================================
  // Baud tick
  asr_baud_gen u_brg (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .enable_in(s.rc_ctrl[SERIAL_PORT_ENABLE_BIT]),
    .restart_in(s.brg_restart),
    .divisor_in({s.div_hi, s.div_lo}),
    .wide_in(s.baud_ctrl[WIDE_BAUD_COUNTER_BIT]),
    .high_in(s.tx_ctrl[HIGH_SPEED_BAUD_BIT]),
    .tick_out(brg_tick)
  );

  // ==========================================================
  // Next state
  always_comb
  begin
    n = s;
    n.brg_restart = 1'b0;
    push_evt = 1'b0;
    pop_evt = 1'b0;
    push_word = '0;
    d9 = 1'b0;
    rd8 = 8'h00;
    port_on = s.rc_ctrl[SERIAL_PORT_ENABLE_BIT] & s.pin_dir[RX_DIR_BIT];
    rx_on = port_on & s.rc_ctrl[CONTINUOUS_RECEIVE_ENABLE_BIT] & ~s.tx_ctrl[SYNC_BIT];
    top = s.mem[s.fifo_rd];
    has = s.fifo_cnt != 2'h0;

    // Pin synchroniser; level accepted once stages two and three agree
    n.sync = {s.sync[1:0], receive_pin_in};
    if (s.sync[1] == s.sync[2])
    begin
      n.line = s.sync[2];
    end
    n.line_prev = s.line;
    level = s.line ^ s.baud_ctrl[RECEIVE_POLARITY_INVERT_BIT];
    fall = (s.line_prev ^ s.baud_ctrl[RECEIVE_POLARITY_INVERT_BIT]) & ~level;
    vote = asr_maj3(s.smp[0], s.smp[1], level);

    // Bus address phase
    if (hsel_in && htrans_in[1] && hready_in)
    begin
      n.dp_act = 1'b1;
      n.hready = 1'b0;
      n.dp_write = hwrite_in;
      n.dp_addr = haddr_in[7:0];
      n.dp_hit = (haddr_in[31:8] == 24'h000000) && (hsize_in == HSIZE_WORD) && (haddr_in[1:0] == 2'h0);
    end

    // Read mux
    case (s.dp_addr)
      OFS_TX_CTRL:
      begin
        rd8 = s.tx_ctrl;
        rd8[TX_SHIFT_EMPTY_BIT] = 1'b1;
      end
      OFS_RX_CTRL:
      begin
        rd8 = s.rc_ctrl;
        rd8[FRAMING_ERROR_BIT] = has & top.framing_error;
        rd8[OVERRUN_ERROR_BIT] = s.overrun_error;
        rd8[NINTH_RX_BIT_BIT] = has & top.d9;
      end
      OFS_RX_DATA:
      begin
        rd8 = has ? top.data : 8'h00;
      end
      OFS_BAUD_CTRL:
      begin
        rd8 = s.baud_ctrl;
        rd8[RCIDL_BIT] = s.rx_st == RX_IDLE;
      end
      OFS_DIV_LO:
      begin
        rd8 = s.div_lo;
      end
      OFS_DIV_HI:
      begin
        rd8 = s.div_hi;
      end
      OFS_PIN_DIR:
      begin
        rd8 = {6'h00, s.pin_dir};
      end
      OFS_IRQ_CTRL:
      begin
        rd8[IRQ_EN_BIT] = s.irq_en;
        rd8[IRQ_FLAG_BIT] = s.flag;
      end
      default:
      begin
        rd8 = 8'h00;
      end
    endcase

    // Bus data phase: one wait state, then answer
    if (s.dp_act && !s.hready)
    begin
      n.dp_act = 1'b0;
      n.hready = 1'b1;
      n.hrdata = (s.dp_hit && !s.dp_write) ? {24'h000000, rd8} : 32'h00000000;
      if (s.dp_hit && s.dp_write)
      begin
        case (s.dp_addr)
          OFS_TX_CTRL:
          begin
            n.tx_ctrl = hwdata_in[7:0] & TX_WR_MASK;
          end
          OFS_RX_CTRL:
          begin
            n.rc_ctrl = hwdata_in[7:0] & RC_WR_MASK;
          end
          OFS_BAUD_CTRL:
          begin
            n.baud_ctrl = hwdata_in[7:0] & BAUD_WR_MASK;
          end
          OFS_DIV_LO:
          begin
            n.div_lo = hwdata_in[7:0];
            n.brg_restart = 1'b1;
          end
          OFS_DIV_HI:
          begin
            n.div_hi = hwdata_in[7:0];
            n.brg_restart = 1'b1;
          end
          OFS_PIN_DIR:
          begin
            n.pin_dir = hwdata_in[1:0];
          end
          OFS_IRQ_CTRL:
          begin
            n.irq_en = hwdata_in[IRQ_EN_BIT];
          end
          default:
          begin
            n.irq_en = s.irq_en;
          end
        endcase
      end
      else if (s.dp_hit && s.dp_addr == OFS_RX_DATA && has)
      begin
        pop_evt = 1'b1;
      end
    end

    // Buffer read advances to the next character
    if (pop_evt)
    begin
      n.fifo_rd = ~s.fifo_rd;
      n.fifo_cnt = s.fifo_cnt - 2'h1;
    end

    // Overrun cleared while continuous receive is off
    if (!s.rc_ctrl[CONTINUOUS_RECEIVE_ENABLE_BIT])
    begin
      n.overrun_error = 1'b0;
    end

    // Receiver
    if (!rx_on)
    begin
      n.rx_st = RX_IDLE;
    end
    else if (s.rx_st == RX_IDLE)
    begin
      if (fall && !s.overrun_error)
      begin
        n.rx_st = RX_START;
        n.phase = 4'h0;
        n.bit_idx = 4'h0;
        n.shift = 9'h000;
      end
    end
    else if (brg_tick)
    begin
      n.phase = s.phase + 4'h1;
      if (s.phase == VOTE_A)
      begin
        n.smp[0] = level;
      end
      if (s.phase == VOTE_B)
      begin
        n.smp[1] = level;
      end
      if (s.phase == VOTE_C)
      begin
        case (s.rx_st)
          RX_START:
          begin
            n.rx_st = vote ? RX_IDLE : RX_DATA;
          end
          RX_DATA:
          begin
            n.shift[s.bit_idx] = vote;
            if (s.bit_idx == (s.rc_ctrl[RX9_BIT] ? LAST_BIT_9 : LAST_BIT_8))
            begin
              n.rx_st = RX_STOP;
            end
            else
            begin
              n.bit_idx = s.bit_idx + 4'h1;
            end
          end
          RX_STOP:
          begin
            n.rx_st = RX_IDLE;
            d9 = s.rc_ctrl[RX9_BIT] & s.shift[8];
            push_word = '{framing_error: ~vote, d9: d9, data: s.shift[7:0]};
            if (s.rc_ctrl[RX9_BIT] && s.rc_ctrl[ADDRESS_DETECT_ENABLE_BIT] && !d9)
            begin
              push_evt = 1'b0;
            end
            else if (n.fifo_cnt == FIFO_DEPTH)
            begin
              n.overrun_error = 1'b1;
            end
            else
            begin
              push_evt = 1'b1;
              n.mem[n.fifo_rd ^ n.fifo_cnt[0]] = push_word;
              n.fifo_cnt = n.fifo_cnt + 2'h1;
            end
          end
          default:
          begin
            n.rx_st = RX_IDLE;
          end
        endcase
      end
    end

    // Port disable resets receiver, buffer and errors
    if (!port_on)
    begin
      n.rx_st = RX_IDLE;
      n.fifo_cnt = 2'h0;
      n.fifo_rd = 1'b0;
      n.overrun_error = 1'b0;
    end

    n.flag = n.fifo_cnt != 2'h0;
    n.irq = n.flag & n.irq_en;
  end

  // ==========================================================
  // State register
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      s <= '0;
      s.hready <= 1'b1;
    end
    else
    begin
      s <= n;
    end
  end

  assign hreadyout_out = s.hready;
  assign hrdata_out = s.hrdata;
  assign hresp_out = 1'b0;
  assign receive_flag_out = s.flag;
  assign receive_irq_out = s.irq;

  // ==========================================================
  // Assertions
  property p_flag_on_push;
    @(posedge clock_in) disable iff (rst_in)
    push_evt |=> receive_flag_out ##0 (receive_irq_out == s.irq_en);
  endproperty
  a_flag_on_push: assert property (p_flag_on_push) else $error("flag not raised after buffer load");

  property p_rx_off_idle;
    @(posedge clock_in) disable iff (rst_in)
    !s.rc_ctrl[CONTINUOUS_RECEIVE_ENABLE_BIT] |=> (s.rx_st == RX_IDLE);
  endproperty
  a_rx_off_idle: assert property (p_rx_off_idle) else $error("receiver active with receive disabled");

  property p_overrun_error_clear;
    @(posedge clock_in) disable iff (rst_in)
    (s.overrun_error && !s.rc_ctrl[CONTINUOUS_RECEIVE_ENABLE_BIT]) |=> !s.overrun_error;
  endproperty
  a_overrun_error_clear: assert property (p_overrun_error_clear) else $error("overrun not cleared");

  property p_overrun_error_blocks;
    @(posedge clock_in) disable iff (rst_in)
    s.overrun_error |-> (s.rx_st == RX_IDLE) && (s.fifo_cnt <= FIFO_DEPTH) && !push_evt;
  endproperty
  a_overrun_error_blocks: assert property (p_overrun_error_blocks) else $error("reception during overrun");

  property p_addr_ninth;
    @(posedge clock_in) disable iff (rst_in)
    (push_evt && s.rc_ctrl[RX9_BIT] && s.rc_ctrl[ADDRESS_DETECT_ENABLE_BIT]) |-> push_word.d9;
  endproperty
  a_addr_ninth: assert property (p_addr_ninth) else $error("address mode delivered ninth bit zero");

  property p_start_abort;
    @(posedge clock_in) disable iff (rst_in)
    (rx_on && s.rx_st == RX_START && brg_tick && s.phase == VOTE_C && vote) |=> (s.rx_st == RX_IDLE);
  endproperty
  a_start_abort: assert property (p_start_abort) else $error("false start not aborted");

  property p_shift_on_tick;
    @(posedge clock_in) disable iff (rst_in)
    ($changed(s.bit_idx) && s.bit_idx != 4'h0) |-> $past(brg_tick) && ($past(s.phase) == VOTE_C);
  endproperty
  a_shift_on_tick: assert property (p_shift_on_tick) else $error("bit advanced off centre");

  property p_nine_bits;
    @(posedge clock_in) disable iff (rst_in)
    (s.rx_st == RX_DATA && n.rx_st == RX_STOP) |-> (s.bit_idx == (s.rc_ctrl[RX9_BIT] ? LAST_BIT_9 : LAST_BIT_8));
  endproperty
  a_nine_bits: assert property (p_nine_bits) else $error("wrong data bit count");

  property p_framing_error_stop;
    @(posedge clock_in) disable iff (rst_in)
    push_evt |-> (push_word.framing_error == !vote);
  endproperty
  a_framing_error_stop: assert property (p_framing_error_stop) else $error("framing error mismatch");

  property p_port_off;
    @(posedge clock_in) disable iff (rst_in)
    !port_on |=> (s.fifo_cnt == 2'h0) && (s.rx_st == RX_IDLE) ##1 !receive_flag_out;
  endproperty
  a_port_off: assert property (p_port_off) else $error("disabled port holds data");

  property p_data_low_byte;
    @(posedge clock_in) disable iff (rst_in)
    (s.dp_act && !s.hready && s.dp_hit && !s.dp_write && s.dp_addr == OFS_RX_DATA)
      |=> hreadyout_out && (hrdata_out[31:8] == 24'h000000);
  endproperty
  a_data_low_byte: assert property (p_data_low_byte) else $error("data read wider than a byte");

endmodule

`default_nettype wire

/* testbench/asr_tx_model.sv */
/*
  Line model of the remote transmitter: start bit, 8 or 9 data bits LSB first,
  one stop bit, bit_clks clocks per bit (sixteen by default).
  Assumes bit_clks is set to sixteen sample ticks of the receiver's divider.
*/
`timescale 1ns/1ps
`default_nettype none

module asr_tx_model
(
  // Clock
  input wire logic clock_in,
  // Serial line
  output logic line_out
);
  logic inv = 1'b0;
  int bit_clks = 16;

  initial line_out = 1'b1;

  // ==========================================================
  // One bit time, changed just after an edge
  task automatic put(input logic b);
    @(posedge clock_in);
    line_out <= b ^ inv;
    repeat (bit_clks - 1) @(posedge clock_in);
  endtask

  task automatic send(input logic [8:0] d, input int nbits, input logic stop);
    int i;
    put(1'b0);
    for (i = 0; i < nbits; i++)
      put(d[i]);
    put(stop);
    @(posedge clock_in);
    line_out <= ~inv;
  endtask

  // Short low pulse, gone before the half-bit check
  task automatic glitch();
    @(posedge clock_in);
    line_out <= inv;
    repeat (3) @(posedge clock_in);
    line_out <= ~inv;
  endtask

  task automatic set_inv(input logic x);
    @(posedge clock_in);
    inv = x;
    line_out <= ~x;
  endtask
endmodule

`default_nettype wire

/* testbench/testbench.sv */
/*
  Self-checking bench of the serial receiver: AHB-Lite register tasks and
  directed frame sequences with expected register contents.
  Assumes asr_top, asr_pkg and the line model asr_tx_model.
*/
`timescale 1ns/1ps
`default_nettype none

module testbench
  import asr_pkg::*;
;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = HSIZE_WORD;
  logic [31:0] hwdata = 32'h0;
  logic hready;
  logic [31:0] hrdata;
  logic hresp;
  wire logic line;
  logic flag;
  logic irq;
  int mismatches = 0;
  int n_compared = 0;
  int cycles = 0;

  always #25 clock_in = ~clock_in;

  asr_top i_asr_top (.clock_in(clock_in), .rst_in(rst_in), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hready),
    .hreadyout_out(hready), .hrdata_out(hrdata), .hresp_out(hresp), .receive_pin_in(line),
    .receive_flag_out(flag), .receive_irq_out(irq));

  asr_tx_model i_asr_tx_model (.clock_in(clock_in), .line_out(line));

  // ==========================================================
  // Checking and closing
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge clock_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      complete_run();
    end
  end

  // ==========================================================
  // AHB-Lite single word transfer
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rdv);
    @(posedge clock_in);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clock_in); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clock_in); while (hready !== 1'b1);
    rdv = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    check(r, e);
  endtask

  task automatic wait_flag(input logic e);
    int i;
    for (i = 0; i < 40 && flag !== 1'b1; i++)
      @(posedge clock_in);
    check({31'h0, flag}, {31'h0, e});
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    repeat (12) @(posedge clock_in);
    rst_in <= 1'b0;
    rd(OFS_TX_CTRL, 32'h02);
    check({31'h0, hresp}, 32'h0);
    rd(OFS_RX_CTRL, 32'h00);
    rd(OFS_BAUD_CTRL, 32'h40);
    rd(OFS_RX_DATA, 32'h00);
    rd(8'h20, 32'h00);
    wr(OFS_RX_CTRL, 32'h07);
    rd(OFS_RX_CTRL, 32'h00);
    wr(OFS_DIV_LO, 32'h00);
    wr(OFS_DIV_HI, 32'h00);
    wr(OFS_TX_CTRL, 32'h04);
    rd(OFS_TX_CTRL, 32'h06);
    wr(OFS_PIN_DIR, 32'h03);
    wr(OFS_RX_CTRL, 32'h80);
    wr(OFS_IRQ_CTRL, 32'h01);
    i_asr_tx_model.send(9'h0a5, 8, 1'b1);
    wait_flag(1'b0);
    wr(OFS_RX_CTRL, 32'h90);
    i_asr_tx_model.glitch();
    wait_flag(1'b0);
    i_asr_tx_model.send(9'h0a5, 8, 1'b1);
    wait_flag(1'b1);
    check({31'h0, irq}, 32'h1);
    rd(OFS_IRQ_CTRL, 32'h03);
    rd(OFS_RX_CTRL, 32'h90);
    rd(OFS_RX_DATA, 32'ha5);
    rd(OFS_RX_DATA, 32'h00);
    check({31'h0, flag}, 32'h0);
    // Framing error with the interrupt masked
    wr(OFS_IRQ_CTRL, 32'h00);
    i_asr_tx_model.send(9'h03c, 8, 1'b0);
    wait_flag(1'b1);
    check({31'h0, irq}, 32'h0);
    rd(OFS_RX_CTRL, 32'h94);
    rd(OFS_RX_DATA, 32'h3c);
    // Overrun: three back-to-back, then a fourth while blocked
    i_asr_tx_model.send(9'h011, 8, 1'b1);
    i_asr_tx_model.send(9'h022, 8, 1'b1);
    i_asr_tx_model.send(9'h033, 8, 1'b1);
    wait_flag(1'b1);
    rd(OFS_RX_CTRL, 32'h92);
    rd(OFS_RX_DATA, 32'h11);
    i_asr_tx_model.send(9'h044, 8, 1'b1);
    rd(OFS_RX_DATA, 32'h22);
    rd(OFS_RX_DATA, 32'h00);
    wr(OFS_RX_CTRL, 32'h80);
    rd(OFS_RX_CTRL, 32'h80);
    // Nine-bit address detection
    wr(OFS_RX_CTRL, 32'hc0);
    wr(OFS_RX_CTRL, 32'hc8);
    wr(OFS_RX_CTRL, 32'hd8);
    i_asr_tx_model.send(9'h055, 9, 1'b1);
    wait_flag(1'b0);
    i_asr_tx_model.send(9'h13c, 9, 1'b1);
    wait_flag(1'b1);
    rd(OFS_RX_CTRL, 32'hd9);
    rd(OFS_RX_DATA, 32'h3c);
    wr(OFS_RX_CTRL, 32'hd0);
    i_asr_tx_model.send(9'h077, 9, 1'b1);
    wait_flag(1'b1);
    rd(OFS_RX_CTRL, 32'hd0);
    rd(OFS_RX_DATA, 32'h77);
    // Inverted polarity, switched while reception is off
    wr(OFS_RX_CTRL, 32'h80);
    wr(OFS_BAUD_CTRL, 32'h20);
    rd(OFS_BAUD_CTRL, 32'h60);
    i_asr_tx_model.set_inv(1'b1);
    wr(OFS_RX_CTRL, 32'h90);
    i_asr_tx_model.send(9'h0c3, 8, 1'b1);
    wait_flag(1'b1);
    rd(OFS_RX_DATA, 32'hc3);
    // Slow divider: four clocks a tick, 64 clocks a bit
    wr(OFS_TX_CTRL, 32'h00);
    i_asr_tx_model.bit_clks = 64;
    i_asr_tx_model.send(9'h05a, 8, 1'b1);
    wait_flag(1'b1);
    rd(OFS_RX_DATA, 32'h5a);
    // Wide counter with divisor 1: two clocks a tick
    wr(OFS_DIV_LO, 32'h01);
    wr(OFS_BAUD_CTRL, 32'h28);
    i_asr_tx_model.bit_clks = 32;
    i_asr_tx_model.send(9'h096, 8, 1'b1);
    wait_flag(1'b1);
    rd(OFS_RX_DATA, 32'h96);
    // Synchronous mode select blocks asynchronous reception
    wr(OFS_TX_CTRL, 32'h14);
    i_asr_tx_model.send(9'h05a, 8, 1'b1);
    wait_flag(1'b0);
    wr(OFS_TX_CTRL, 32'h00);
    // Receive pin direction cleared disables the port
    wr(OFS_PIN_DIR, 32'h02);
    i_asr_tx_model.send(9'h0c3, 8, 1'b1);
    wait_flag(1'b0);
    complete_run();
  end
endmodule

`default_nettype wire
